// ==== pkg/acs_pkg.sv ====
// Constants, register map and state record of the conversion sequencer.
// Assumes a single core clock and a plain strobe-based register port.
package acs_pkg;

   // Register byte offsets on the register port.
   localparam logic [5:0] ACS_OFS_CONTROL_A_REG = 6'h00;
   localparam logic [5:0] ACS_OFS_CONTROL_B_REG = 6'h04;
   localparam logic [5:0] ACS_OFS_SAMP = 6'h08;
   localparam logic [5:0] ACS_OFS_AVG = 6'h0c;
   localparam logic [5:0] ACS_OFS_INSEL = 6'h10;
   localparam logic [5:0] ACS_OFS_SOFTWARE_TRIGGER_REG = 6'h14;
   localparam logic [5:0] ACS_OFS_IENSET = 6'h18;
   localparam logic [5:0] ACS_OFS_IENCLR = 6'h1c;
   localparam logic [5:0] ACS_OFS_IFLAG = 6'h20;
   localparam logic [5:0] ACS_OFS_RESULT = 6'h24;
   localparam logic [5:0] ACS_OFS_DBG = 6'h28;

   // Field positions.
   localparam int ACS_CA_SOFT_RESET_BIT = 0;
   localparam int ACS_CA_ENABLE = 1;
   localparam int ACS_CB_DIFF = 0;
   localparam int ACS_CB_FREE = 1;
   localparam int ACS_CB_RES_LO = 2;
   localparam int ACS_CB_PRE_LO = 4;
   localparam int ACS_CB_EVTEN = 7;
   localparam int ACS_SW_START = 1;
   localparam int ACS_FL_RESULT_READY_FLAG = 0;
   localparam int ACS_FL_OVR = 1;

   // Resolution select codes; code 1 is the accumulation setting.
   localparam logic [1:0] ACS_RES_12 = 2'h0;
   localparam logic [1:0] ACS_RES_ACC = 2'h1;
   localparam logic [1:0] ACS_RES_10 = 2'h2;
   localparam logic [1:0] ACS_RES_8 = 2'h3;

   // Gain codes and accumulation limits.
   localparam logic [3:0] ACS_GAIN_MAX = 4'h4;
   localparam logic [3:0] ACS_GAIN_HALF = 4'hf;
   localparam logic [3:0] ACS_SNUM_MAX = 4'ha;
   localparam logic [3:0] ACS_SNUM_SHIFT0 = 4'h4;

   // Sampling phase length in half converter periods before extension.
   localparam logic [7:0] ACS_SAMPLE_HALVES = 8'h01;
   // Leading converter period of a single shot, in half periods.
   localparam logic [7:0] ACS_LEAD_HALVES = 8'h02;

   typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT} acs_state_t;

   // Whole state of the sequencer apart from the prescaler, registered in one place.
   typedef struct packed {
      acs_state_t state;
      logic enable;
      logic diff;
      logic freerun;
      logic evt_en;
      logic [1:0] resolution_select;
      logic [2:0] presc;
      logic [5:0] sample_length_field;
      logic [3:0] snum;
      logic [3:0] gain;
      logic [1:0] inten;
      logic [1:0] flags;
      logic [15:0] result;
      logic dbg;
      logic [31:0] rdata;
      logic start_pend;
      logic first;
      logic [7:0] halfcnt;
      logic [10:0] samp_cnt;
      logic [21:0] acc;
      logic s_diff;
      logic s_free;
      logic [1:0] s_res;
      logic [3:0] s_gain;
      logic [5:0] s_sample_length_field;
      logic [3:0] s_snum;
      logic ana_sample;
      logic ana_convert;
      logic [1:0] flag_req;
      logic busy;
   } acs_st_t;

   localparam acs_st_t ACS_ST_RST = '{state: ACS_IDLE, default: '0};

endpackage

// ==== core/acs_presc.sv ====
// Programmable prescaler of the conversion sequencer.
// Assumes the core clock; emits one-cycle ticks, one per half period.
`timescale 1ns/100ps
module acs_presc #(
   parameter int CW = 9
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Control.
   input wire logic run,
   input wire logic [2:0] sel,
   // Half-period tick.
   output logic half_tick_r
);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [CW-1:0] lim;
   logic tick_nxt;

   // Division by four times two to the select gives two ticks per period.
   always_comb begin
      lim = CW'((2 << sel) - 1);
      tick_nxt = 1'b0;
      cnt_nxt = '0;
      if (run) begin
         if (cnt_r >= lim) begin
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   // Stopping clears the count so each run starts with a full half period.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         half_tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         half_tick_r <= tick_nxt;
      end
   end
endmodule

// ==== core/acs_seq.sv ====
// Conversion sequencer: registers, trigger, timing, accumulation, flags.
// Assumes the converter core returns a 12-bit sample on conv_data that is
// stable when the convert phase ends, synchronous to core_clk.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
// Function
// - enable bit starts, zero write stops converter
// - soft reset clears all but debug register
// - start bit or automatic trigger begins conversion
// - free-run restarts after first launched conversion
// - each result overwrites the result register
// - unread result replaced sets overrun flag
// - ready flag rises once result visible
// - enable-set bits enable matching flag sources
// - prescaler divides converter clock for conversions
// - single shot latency one plus half resolution plus gain
// - free-run latency half resolution plus gain
// - gain code table adds zero to three periods
// - resolution select eight ten twelve, twelve default
// - differential bit selects differential in both modes
// - synchronized start, sample in first half period
// - sample length field extends sampling phase
// - sample count accumulates two-power samples up to 1024
// - sums beyond sixteen samples shifted right automatically
module acs_seq
   import acs_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [5:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Automatic trigger and converter core.
   input wire logic trig_evt,
   input wire logic [11:0] conv_data,
   output logic ana_sample,
   output logic ana_convert,
   output logic ana_diff,
   output logic [3:0] ana_gain,
   output logic [1:0] ana_res,
   // Flag requests gated by the enables.
   output logic [1:0] flag_req,
   output logic busy
);
   import acs_pkg::*;

   acs_st_t s_r;
   acs_st_t s_nxt;
   logic tick;

   // The prescaler only runs while enabled, so a disabled block is quiet.
   acs_presc #(.CW(9)) u_presc (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .run(s_r.enable),
      .sel(s_r.presc),
      .half_tick_r(tick)
   );

   // Gain delay in half periods; reserved codes add nothing.
   function automatic logic [7:0] gain_halves(input logic [3:0] g,
                                              input logic d,
                                              input logic fr);
      logic [2:0] k;
      // Half gain takes the delays of the 2x setting in every mode.
      k = (g == ACS_GAIN_HALF) ? 3'h2 : 3'(g) + 3'h1;
      if (g > ACS_GAIN_MAX && g != ACS_GAIN_HALF) begin
         gain_halves = 8'h00;
      end else if (fr) begin
         case (k)
            3'h1: gain_halves = 8'h00;
            3'h2: gain_halves = d ? 8'h00 : 8'h02;
            3'h3: gain_halves = 8'h02;
            3'h4: gain_halves = d ? 8'h02 : 8'h04;
            default: gain_halves = 8'h04;
         endcase
      end else begin
         gain_halves = 8'(k) - 8'h01 + (d ? 8'h00 : 8'h02);
      end
   endfunction

   // Half resolution in periods equals the resolution in half periods.
   function automatic logic [7:0] res_halves(input logic [1:0] r);
      case (r)
         ACS_RES_10: res_halves = 8'h0a;
         ACS_RES_8: res_halves = 8'h08;
         default: res_halves = 8'h0c;
      endcase
   endfunction

   logic [7:0] lat_halves;
   logic [7:0] samp_end;
   logic [11:0] sample;
   logic [10:0] n_samp;
   logic [21:0] acc_sum;
   logic [3:0] shift;
   logic last;
   logic new_result;
   logic go;

   // Timing and accumulation arithmetic for the running conversion.
   always_comb begin
      samp_end = ACS_SAMPLE_HALVES + 8'(s_r.s_sample_length_field);
      if (s_r.first) begin
         lat_halves = ACS_LEAD_HALVES + res_halves(s_r.s_res)
            + gain_halves(s_r.s_gain, s_r.s_diff, 1'b0);
      end else begin
         lat_halves = res_halves(s_r.s_res)
            + gain_halves(s_r.s_gain, s_r.s_diff, 1'b1);
      end
      lat_halves = lat_halves + 8'(s_r.s_sample_length_field);
      case (s_r.s_res)
         ACS_RES_10: sample = {2'h0, conv_data[11:2]};
         ACS_RES_8: sample = {4'h0, conv_data[11:4]};
         default: sample = conv_data;
      endcase
      // Reserved counts fall back to single unshifted results at the selected resolution.
      n_samp = (s_r.s_snum > ACS_SNUM_MAX) ? 11'h001
         : 11'(11'h001 << s_r.s_snum);
      shift = (s_r.s_snum > ACS_SNUM_SHIFT0 && s_r.s_snum <= ACS_SNUM_MAX)
         ? s_r.s_snum - ACS_SNUM_SHIFT0 : 4'h0;
      if (s_r.samp_cnt == 11'h000) begin
         acc_sum = {10'h000, sample};
      end else begin
         acc_sum = s_r.acc + {10'h000, sample};
      end
      last = (s_r.samp_cnt == n_samp - 11'h001);
      new_result = (s_r.state == ACS_CONVERT) && tick
         && (s_r.halfcnt + 8'h01 >= lat_halves) && last;
      go = s_r.start_pend && s_r.enable && tick && s_r.state == ACS_IDLE;
   end

   // Next state: register port, trigger, sequencing and flags.
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = '0;
      // A trigger while disabled is dropped rather than held for later.
      if (trig_evt && s_r.evt_en && s_r.enable) begin
         s_nxt.start_pend = 1'b1;
      end
      if (reg_wr) begin
         case (reg_addr)
            ACS_OFS_CONTROL_A_REG: s_nxt.enable = reg_wdata[ACS_CA_ENABLE];
            ACS_OFS_CONTROL_B_REG: begin
               s_nxt.diff = reg_wdata[ACS_CB_DIFF];
               s_nxt.freerun = reg_wdata[ACS_CB_FREE];
               s_nxt.resolution_select = reg_wdata[ACS_CB_RES_LO +: 2];
               s_nxt.presc = reg_wdata[ACS_CB_PRE_LO +: 3];
               s_nxt.evt_en = reg_wdata[ACS_CB_EVTEN];
            end
            ACS_OFS_SAMP: s_nxt.sample_length_field = reg_wdata[5:0];
            ACS_OFS_AVG: s_nxt.snum = reg_wdata[3:0];
            ACS_OFS_INSEL: s_nxt.gain = reg_wdata[3:0];
            ACS_OFS_SOFTWARE_TRIGGER_REG: begin
               if (reg_wdata[ACS_SW_START] && s_r.enable) begin
                  s_nxt.start_pend = 1'b1;
               end
            end
            ACS_OFS_IENSET: s_nxt.inten = s_r.inten | reg_wdata[1:0];
            ACS_OFS_IENCLR: s_nxt.inten = s_r.inten & ~reg_wdata[1:0];
            ACS_OFS_IFLAG: s_nxt.flags = s_r.flags & ~reg_wdata[1:0];
            ACS_OFS_DBG: s_nxt.dbg = reg_wdata[0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            ACS_OFS_CONTROL_A_REG: s_nxt.rdata = {30'h0, s_r.enable, 1'b0};
            ACS_OFS_CONTROL_B_REG: s_nxt.rdata = {24'h0, s_r.evt_en, s_r.presc,
               s_r.resolution_select, s_r.freerun, s_r.diff};
            ACS_OFS_SAMP: s_nxt.rdata = {26'h0, s_r.sample_length_field};
            ACS_OFS_AVG: s_nxt.rdata = {28'h0, s_r.snum};
            ACS_OFS_INSEL: s_nxt.rdata = {28'h0, s_r.gain};
            ACS_OFS_IENSET: s_nxt.rdata = {30'h0, s_r.inten};
            ACS_OFS_IENCLR: s_nxt.rdata = {30'h0, s_r.inten};
            ACS_OFS_IFLAG: s_nxt.rdata = {30'h0, s_r.flags};
            ACS_OFS_RESULT: begin
               s_nxt.rdata = {16'h0, s_r.result};
               s_nxt.flags[ACS_FL_RESULT_READY_FLAG] = 1'b0;
            end
            ACS_OFS_DBG: s_nxt.rdata = {31'h0, s_r.dbg};
            default: s_nxt.rdata = '0;
         endcase
      end
      // Sequencing runs on prescaler ticks only.
      case (s_r.state)
         ACS_IDLE: begin
            if (go) begin
               // Config is copied here, so later writes wait for the next start from idle.
               s_nxt.s_diff = s_r.diff;
               s_nxt.s_free = s_r.freerun;
               s_nxt.s_res = s_r.resolution_select;
               s_nxt.s_gain = s_r.gain;
               s_nxt.s_sample_length_field = s_r.sample_length_field;
               s_nxt.s_snum = s_r.snum;
               s_nxt.start_pend = 1'b0;
               s_nxt.first = 1'b1;
               s_nxt.samp_cnt = '0;
               s_nxt.halfcnt = '0;
               s_nxt.state = ACS_SAMPLE;
               s_nxt.ana_sample = 1'b1;
            end
         end
         ACS_SAMPLE: begin
            if (tick) begin
               s_nxt.halfcnt = s_r.halfcnt + 8'h01;
               if (s_r.halfcnt + 8'h01 >= samp_end) begin
                  s_nxt.state = ACS_CONVERT;
                  s_nxt.ana_sample = 1'b0;
                  s_nxt.ana_convert = 1'b1;
               end
            end
         end
         ACS_CONVERT: begin
            if (tick && s_r.halfcnt + 8'h01 >= lat_halves) begin
               s_nxt.acc = acc_sum;
               s_nxt.halfcnt = '0;
               s_nxt.first = 1'b0;
               s_nxt.ana_convert = 1'b0;
               s_nxt.samp_cnt = last ? 11'h000 : s_r.samp_cnt + 11'h001;
               if (!last || s_r.s_free) begin
                  s_nxt.state = ACS_SAMPLE;
                  s_nxt.ana_sample = 1'b1;
               end else begin
                  s_nxt.state = ACS_IDLE;
               end
            end else begin
               s_nxt.halfcnt = tick ? s_r.halfcnt + 8'h01 : s_r.halfcnt;
            end
         end
         default: s_nxt.state = ACS_IDLE;
      endcase
      // A finished result wins over a clear or a read in the same cycle.
      if (new_result) begin
         s_nxt.result = 16'(acc_sum >> shift);
         s_nxt.flags[ACS_FL_RESULT_READY_FLAG] = 1'b1;
         if (s_r.flags[ACS_FL_RESULT_READY_FLAG]) begin
            s_nxt.flags[ACS_FL_OVR] = 1'b1;
         end
      end
      // Disabling aborts the running conversion and drops pending starts.
      if (!s_nxt.enable) begin
         s_nxt.state = ACS_IDLE;
         s_nxt.ana_sample = 1'b0;
         s_nxt.ana_convert = 1'b0;
         s_nxt.start_pend = 1'b0;
      end
      // Soft reset keeps only the debug setting; read data of the same cycle is cleared too.
      if (reg_wr && reg_addr == ACS_OFS_CONTROL_A_REG
          && reg_wdata[ACS_CA_SOFT_RESET_BIT]) begin
         s_nxt = ACS_ST_RST;
         s_nxt.dbg = s_r.dbg;
      end
      s_nxt.flag_req = s_nxt.flags & s_nxt.inten;
      s_nxt.busy = (s_nxt.state != ACS_IDLE);
   end

   // All state but the prescaler count and tick lives in one record.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= ACS_ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state record.
   assign reg_rdata = s_r.rdata;
   assign ana_sample = s_r.ana_sample;
   assign ana_convert = s_r.ana_convert;
   assign ana_diff = s_r.s_diff;
   assign ana_gain = s_r.s_gain;
   assign ana_res = s_r.s_res;
   assign flag_req = s_r.flag_req;
   assign busy = s_r.busy;
endmodule

// ==== tb/acs_conv_model.sv ====
// Behavioural converter core at the far side of the sequencer.
// Assumes the sequencer samples conv_data while ana_convert is high.
`timescale 1ns/100ps
module acs_conv_model (
   // Phase input from the sequencer.
   input wire logic ana_convert,
   // Analog level as a 12-bit code, and the returned sample.
   input wire logic [11:0] level,
   output logic [11:0] conv_data
);
   // Outside the convert phase nothing is valid, so show the inverse.
   assign conv_data = ana_convert ? level : ~level;
endmodule

// ==== tb/acs_seq_props.sv ====
// Concurrent checks on the ports of the conversion sequencer.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module acs_seq_props
   import acs_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [5:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Converter side and flags.
   input wire logic ana_sample,
   input wire logic ana_convert,
   input wire logic ana_diff,
   input wire logic [3:0] ana_gain,
   input wire logic [1:0] ana_res,
   input wire logic [1:0] flag_req,
   input wire logic busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Control writes that stop or reset the converter.
   sequence s_stop_wr;
      reg_wr && reg_addr == ACS_OFS_CONTROL_A_REG && !reg_wdata[ACS_CA_ENABLE];
   endsequence
   sequence s_soft_reset_bit_wr;
      reg_wr && reg_addr == ACS_OFS_CONTROL_A_REG && reg_wdata[ACS_CA_SOFT_RESET_BIT];
   endsequence
   chk_stop_halts: assert property (s_stop_wr |-> ##[1:2] !busy)
      else $error("still busy after disable");
   chk_soft_reset_bit_clears: assert property (s_soft_reset_bit_wr |->
      ##[1:2] (flag_req == 2'h0 && !busy && ana_gain == 4'h0))
      else $error("state left after soft reset");
   chk_phase_busy: assert property ((ana_sample || ana_convert) |-> busy)
      else $error("phase active while idle");
   chk_no_overlap: assert property (!(ana_sample && ana_convert))
      else $error("sample and convert overlap");
   chk_samp_conv: assert property ($fell(ana_sample) && busy |-> ana_convert)
      else $error("sampling not followed by convert");
   chk_sample_len: assert property ($rose(ana_sample) |=> ana_sample || !busy)
      else $error("sampling phase too short");
   chk_rdy_after_conv: assert property ($rose(flag_req[0]) && !$past(reg_wr)
      |-> $past(ana_convert) || $past(ana_convert, 2))
      else $error("ready without a finished convert");
   chk_cfg_stable: assert property (busy && $past(busy) && $past(busy, 2)
      |-> $stable({ana_gain, ana_diff, ana_res}))
      else $error("conversion setup moved mid-run");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its cycle");
endmodule
bind acs_seq acs_seq_props acs_seq_props_i (.core_clk, .rst_b, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ana_sample, .ana_convert,
   .ana_diff, .ana_gain, .ana_res, .flag_req, .busy);

// ==== tb/tb.sv ====
// Self-checking bench of the conversion sequencer.
// Assumes acs_seq at the top and a behavioural converter core beside it.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
n_errors++; $display("wrong value at %0t: got %h want %h", $time, g, e); \
end end
module tb;
   import acs_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic trig_evt = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [11:0] lvl = 12'habc;
   logic [31:0] reg_rdata;
   logic [11:0] conv_data;
   logic ana_sample, ana_convert, ana_diff, busy;
   logic [3:0] ana_gain;
   logic [1:0] ana_res, flag_req;
   int n_errors = 0;
   int samples_checked = 0;
   // Gain codes and their single-shot differential delay in half periods.
   logic [3:0] gc [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
   int gs [6] = '{0, 1, 2, 3, 4, 1};
   // Core clock of 8 ns.
   always #4 core_clk = ~core_clk;
   acs_seq acs_seq_i (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_evt(trig_evt),
      .conv_data(conv_data), .ana_sample(ana_sample),
      .ana_convert(ana_convert), .ana_diff(ana_diff), .ana_gain(ana_gain),
      .ana_res(ana_res), .flag_req(flag_req), .busy(busy));
   acs_conv_model acs_conv_model_i (.ana_convert(ana_convert), .level(lvl),
      .conv_data(conv_data));
   task automatic test_done();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One-cycle register strobes; a gap cycle keeps drivers apart.
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   // Counts cycles until the ready request shows, bounded.
   task automatic waitr(output int n);
      n = 0;
      while (flag_req[0] !== 1'b1 && n < 5000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask
   task automatic conv1(input logic d, input logic [1:0] rs, input int r,
      input logic [2:0] ps, input logic [5:0] sl, input int gi);
      int n, h, t, sh;
      h = 2 << ps;
      t = sl + 2 + r + gs[gi] + (d ? 0 : 2);
      sh = (rs == ACS_RES_10) ? 2 : (rs == ACS_RES_8) ? 4 : 0;
      wr(ACS_OFS_CONTROL_B_REG, {25'h0, ps, rs, 1'b0, d});
      wr(ACS_OFS_SAMP, {26'h0, sl});
      wr(ACS_OFS_INSEL, {28'h0, gc[gi]});
      wr(ACS_OFS_SOFTWARE_TRIGGER_REG, 32'h2);
      waitr(n);
      `CHK(n >= t * h && n <= t * h + h + 4, 1'b1)
      `CHK(ana_gain, gc[gi])
      `CHK(ana_diff, d)
      `CHK(ana_res, rs)
      rd(ACS_OFS_RESULT, {20'h0, lvl} >> sh);
   endtask
   task automatic t_ovr();
      int n;
      wr(ACS_OFS_CONTROL_B_REG, 32'h0);
      wr(ACS_OFS_INSEL, 32'h0);
      wr(ACS_OFS_SOFTWARE_TRIGGER_REG, 32'h2);
      waitr(n);
      wr(ACS_OFS_SOFTWARE_TRIGGER_REG, 32'h2);
      repeat (50) @(posedge core_clk);
      #1;
      `CHK(flag_req, 2'h3)
      wr(ACS_OFS_IENCLR, 32'h1);
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(flag_req, 2'h2)
      wr(ACS_OFS_IENSET, 32'h1);
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(flag_req, 2'h3)
      rd(ACS_OFS_IFLAG, 32'h3);
      wr(ACS_OFS_IFLAG, 32'h3);
      rd(ACS_OFS_IFLAG, 32'h0);
   endtask
   // Free-run: later results follow without the leading period.
   task automatic t_free();
      int n;
      wr(ACS_OFS_INSEL, 32'h4);
      wr(ACS_OFS_SAMP, 32'h0);
      wr(ACS_OFS_CONTROL_B_REG, 32'h3);
      wr(ACS_OFS_SOFTWARE_TRIGGER_REG, 32'h2);
      waitr(n);
      rd(ACS_OFS_RESULT, {20'h0, lvl});
      waitr(n);
      `CHK(n >= 28 && n <= 32, 1'b1)
      wr(ACS_OFS_CONTROL_A_REG, 32'h0);
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(busy, 1'b0)
      wr(ACS_OFS_IFLAG, 32'h3);
   endtask
   task automatic t_acc();
      int n;
      logic [3:0] sc [3];
      logic [15:0] ex [3];
      sc = '{4'h2, 4'h5, 4'hb};
      ex = '{{2'h0, lvl, 2'h0}, {lvl, 4'h0}, {4'h0, lvl}};
      wr(ACS_OFS_CONTROL_A_REG, 32'h2);
      wr(ACS_OFS_CONTROL_B_REG, 32'h4);
      for (int i = 0; i < 3; i++) begin
         wr(ACS_OFS_AVG, {28'h0, sc[i]});
         wr(ACS_OFS_SOFTWARE_TRIGGER_REG, 32'h2);
         waitr(n);
         rd(ACS_OFS_RESULT, {16'h0, ex[i]});
      end
   endtask
   task automatic t_evt();
      int n;
      wr(ACS_OFS_AVG, 32'h0);
      wr(ACS_OFS_CONTROL_B_REG, 32'h80);
      @(posedge core_clk);
      trig_evt <= 1'b1;
      @(posedge core_clk);
      trig_evt <= 1'b0;
      waitr(n);
      `CHK(flag_req[0], 1'b1)
      rd(ACS_OFS_RESULT, {20'h0, lvl});
      wr(ACS_OFS_CONTROL_A_REG, 32'h0);
      @(posedge core_clk);
      trig_evt <= 1'b1;
      @(posedge core_clk);
      trig_evt <= 1'b0;
      wr(ACS_OFS_SOFTWARE_TRIGGER_REG, 32'h2);
      repeat (60) @(posedge core_clk);
      #1;
      `CHK({busy, flag_req}, 3'h0)
   endtask
   // Soft reset is requested only with the converter disabled.
   task automatic t_soft_reset_bit();
      wr(ACS_OFS_DBG, 32'h1);
      wr(ACS_OFS_CONTROL_B_REG, 32'h5);
      wr(ACS_OFS_CONTROL_A_REG, 32'h0);
      wr(ACS_OFS_CONTROL_A_REG, 32'h1);
      rd(ACS_OFS_CONTROL_B_REG, 32'h0);
      rd(ACS_OFS_IENSET, 32'h0);
      rd(ACS_OFS_DBG, 32'h1);
      rd(ACS_OFS_CONTROL_A_REG, 32'h0);
   endtask
   // Main sequence; clock and reference are taken as ready before enable.
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(ACS_OFS_CONTROL_B_REG, 32'h0);
      rd(6'h3c, 32'h0);
      wr(ACS_OFS_IENSET, 32'h3);
      wr(ACS_OFS_CONTROL_A_REG, 32'h2);
      for (int d = 0; d < 2; d++) begin
         for (int g = 0; g < 6; g++) begin
            conv1(d[0], ACS_RES_12, 12, 3'h0, 6'h0, g);
         end
      end
      conv1(1'b0, ACS_RES_10, 10, 3'h1, 6'h0, 0);
      conv1(1'b1, ACS_RES_8, 8, 3'h2, 6'h3, 2);
      t_ovr();
      t_free();
      t_acc();
      t_evt();
      t_soft_reset_bit();
      test_done();
   end
   // Watchdog well past the expected run of a few thousand cycles.
   initial begin
      #400000;
      n_errors++;
      test_done();
   end
endmodule
